// file: common/cfp_cfg.svh
// Register map, field positions, reset values and timing counts of the fault flag block.
`ifndef CFP_CFG_SVH
`define CFP_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define CFP_ADDR_CTRL  8'h00
`define CFP_ADDR_FLAG  8'h01
`define CFP_ADDR_STAT  8'h02
`define CFP_ADDR_LIM   8'h03

// ****************************************
// Control fields
// ****************************************
`define CFP_C_EN       0
`define CFP_C_DIS      3
`define CFP_C_WMSK     6
`define CFP_C_RMSK     7
`define CFP_C_SRST     8
`define CFP_C_WLVL     9
`define CFP_CTRL_W     10
`define CFP_CTRL_RST   10'h000
`define CFP_CTRL_WMASK 10'h2FF
`define CFP_LIM_RST    8'h00

// ****************************************
// Flag fields
// ****************************************
`define CFP_F_LIM      0
`define CFP_F_SHORT    3
`define CFP_F_WARN     6
`define CFP_F_STOP     7
`define CFP_F_HIGH     8
`define CFP_F_RST      9
`define CFP_FLAG_W     10
`define CFP_FLAG_RST   10'h000

// ****************************************
// Timing
// ****************************************
`define CFP_CLK_MHZ      40
`define CFP_T_SD_LIM_US  20
`define CFP_T_SU_LIM_US  64
`define CFP_T_FAULT_MS   1
`define CFP_CYC_SD_LIM   (`CFP_T_SD_LIM_US * `CFP_CLK_MHZ)
`define CFP_CYC_SU_LIM   (`CFP_T_SU_LIM_US * `CFP_CLK_MHZ)
`define CFP_CYC_FAULT    (`CFP_T_FAULT_MS * 1000 * `CFP_CLK_MHZ)

`endif

// file: common/cfp_pkg.sv
// Types shared by the fault flag block.
package cfp_pkg;

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [2:0] {CH_OFF, CH_START, CH_RUN, CH_STOP, CH_FAULT} cfp_ch_e;
	typedef enum logic [1:0] {DEV_SHUTDOWN, DEV_STANDBY, DEV_ACTIVE} cfp_dev_e;

endpackage

// file: logic/cfp_top.sv
// Fault, warning and shutdown flag logic for two step-down and one step-up converter.
`timescale 1ns/100ps
`include "cfp_cfg.svh"
module cfp_top #(
	parameter int unsigned CYC_FAULT = `CFP_CYC_FAULT
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	input  wire logic [1:0]           sd_peak_raw,
	input  wire logic                 su_peak_raw,
	input  wire logic [1:0]           sd_low_raw,
	input  wire logic                 su_low_raw,
	input  wire logic                 su_collapse_raw,
	input  wire logic                 hot_warn_raw,
	input  wire logic                 hot_stop_raw,
	input  wire logic                 input_high_raw,
	input  wire logic                 main_supply_ok_raw,
	input  wire logic [1:0]           sd_ramp,
	input  wire logic                 ecc_single,
	input  wire logic                 ecc_double,
	output logic                      irq_out_n,
	output logic      [2:0]           sw_en,
	output logic      [2:0]           pulldown_en,
	output logic                      gpo_force_low,
	output cfp_pkg::cfp_dev_e         dev_state,
	output logic      [5:0]           stepdown_peak_limit_sel,
	output logic      [1:0]           stepup_peak_limit_sel,
	output logic                      hot_warn_level_sel
);
	import cfp_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [10:0]              s1_reg;
	logic [10:0]              s2_reg;
	wire  [10:0]              raw_in = {main_supply_ok_raw, input_high_raw, hot_stop_raw,
		hot_warn_raw, su_collapse_raw, su_low_raw, sd_low_raw, su_peak_raw, sd_peak_raw};

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= 11'h000;
			s2_reg <= 11'h000;
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
		end
	end

	wire  [2:0]               peak_live = s2_reg[2:0];
	wire  [2:0]               low_live  = s2_reg[5:3];
	wire                      collapse  = s2_reg[6];
	wire                      warn_live = s2_reg[7];
	wire                      stop_live = s2_reg[8];
	wire                      high_live = s2_reg[9];
	wire                      sup_ok    = s2_reg[10];

	// ****************************************
	// Register decode
	// ****************************************
	logic [`CFP_CTRL_W-1:0]   ctrl_reg;
	logic [`CFP_CTRL_W-1:0]   ctrl_next;
	logic [`CFP_FLAG_W-1:0]   flag_reg;
	logic [`CFP_FLAG_W-1:0]   flag_next;
	logic [7:0]               lim_reg;
	logic [7:0]               lim_next;
	logic [1:0]               ecc_reg;
	logic                     warn_d_reg;
	cfp_dev_e                 dev_reg;
	cfp_dev_e                 dev_next;
	logic [15:0]              rdata_next;
	logic [2:0]               short_set;
	logic [2:0]               lim_set;
	logic [2:0]               run_now;
	logic [2:0]               sw_next;
	logic [2:0]               pd_next;

	wire                      ctrl_wr = reg_wr & (reg_addr == `CFP_ADDR_CTRL);
	wire                      flag_wr = reg_wr & (reg_addr == `CFP_ADDR_FLAG);
	wire                      lim_wr  = reg_wr & (reg_addr == `CFP_ADDR_LIM);
	wire                      soft_rst = ctrl_wr & reg_wdata[`CFP_C_SRST];
	// Lockout and soft reset both take the control, flag and limit registers back to their defaults; soft reset leaves the reset flag set.
	wire                      clr_all = ~sup_ok | soft_rst;
	wire                      rst_evt = soft_rst | ((dev_reg == DEV_SHUTDOWN) & sup_ok);
	wire                      kill = ~sup_ok | high_live | stop_live;
	wire                      block = high_live | stop_live | flag_reg[`CFP_F_HIGH]
		| flag_reg[`CFP_F_STOP];
	wire [2:0]                ramp = {1'b0, sd_ramp};

	// ****************************************
	// Converter channels
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_ch
			localparam logic [11:0] LIMN = (i == 2) ? 12'(`CFP_CYC_SU_LIM)
				: 12'(`CFP_CYC_SD_LIM);
			cfp_ch_e              st_reg;
			cfp_ch_e              st_next;
			logic [15:0]          ft_reg;
			logic [15:0]          ft_next;
			logic [11:0]          lt_reg;
			logic [11:0]          lt_next;
			wire                  en_bit = ctrl_reg[`CFP_C_EN + i];
			wire                  en_ok = en_bit & ~block;
			wire                  ft_done = (ft_reg == 16'(CYC_FAULT - 1));
			wire                  colp = (i == 2) & collapse;
			// Limit timing only runs in steady regulation, never during start or a ramp.
			wire                  lim_on = peak_live[i] & (st_reg == CH_RUN) & ~ramp[i];
			wire                  ft_cnt = (st_reg == CH_START) | (st_reg == CH_STOP)
				| ((st_reg == CH_RUN) & low_live[i]);

			always_comb begin
				st_next = st_reg;
				case (st_reg)
					CH_OFF: begin
						if (en_ok) begin
							st_next = CH_START;
						end
					end
					CH_START: begin
						if (colp) begin
							st_next = CH_STOP;
						end else if (ft_done) begin
							st_next = low_live[i] ? CH_FAULT : CH_RUN;
						end
					end
					CH_RUN: begin
						if (colp) begin
							st_next = CH_STOP;
						end else if (ft_done) begin
							st_next = CH_FAULT;
						end
					end
					CH_STOP: begin
						if (ft_done) begin
							st_next = CH_FAULT;
						end
					end
					CH_FAULT: begin
						if (~flag_reg[`CFP_F_SHORT + i]) begin
							st_next = en_ok ? CH_START : CH_OFF;
						end
					end
					default: begin
						st_next = CH_OFF;
					end
				endcase
				if (kill || (!en_bit && st_reg != CH_FAULT)) begin
					st_next = CH_OFF;
				end
			end

			assign ft_next = (st_next != st_reg) ? 16'h0000
				: (ft_cnt ? ft_reg + 16'h0001 : 16'h0000);
			assign lt_next = lim_on ? ((lt_reg == LIMN) ? lt_reg : lt_reg + 12'h001)
				: 12'h000;
			assign lim_set[i] = lim_on & (lt_reg == LIMN - 12'h001);
			assign short_set[i] = (st_reg != CH_FAULT) & (st_next == CH_FAULT);
			assign run_now[i] = (st_reg != CH_OFF) & (st_reg != CH_FAULT);
			// Switching stops in STOP but the output is not discharged until the channel reaches OFF or FAULT.
			assign sw_next[i] = (st_next == CH_START) | (st_next == CH_RUN);
			assign pd_next[i] = ((st_next == CH_OFF) | (st_next == CH_FAULT))
				& (ctrl_next[`CFP_C_DIS + i] | ~sup_ok);

			always_ff @(posedge clk) begin
				if (rst) begin
					st_reg <= CH_OFF;
					ft_reg <= 16'h0000;
					lt_reg <= 12'h000;
				end else begin
					st_reg <= st_next;
					ft_reg <= ft_next;
					lt_reg <= lt_next;
				end
			end
		end
	endgenerate

	// Negative current limiting has no input here, so it can neither flag nor stop.

	// ****************************************
	// Flags and interrupt
	// ****************************************
	wire                      warn_rise = warn_live & ~warn_d_reg;
	wire [`CFP_FLAG_W-1:0]    flag_set = {rst_evt, high_live, stop_live, warn_rise,
		short_set, lim_set};
	// Live overvoltage and hot stop hold their flags against a clearing write.
	wire [`CFP_FLAG_W-1:0]    flag_clr = flag_wr ? (reg_wdata[`CFP_FLAG_W-1:0]
		& ~{1'b0, high_live, stop_live, 7'h00}) : `CFP_FLAG_RST;
	wire [`CFP_FLAG_W-1:0]    flag_mask = {ctrl_next[`CFP_C_RMSK], 2'b00,
		ctrl_next[`CFP_C_WMSK], 6'h00};

	// A flag set in the cycle of its clearing write stays set.
	assign flag_next = clr_all ? {rst_evt, 9'h000}
		: ((flag_reg & ~flag_clr) | flag_set);
	wire                      irq_next = ~|(flag_next & ~flag_mask);

	// ****************************************
	// Control registers
	// ****************************************
	always_comb begin
		ctrl_next = ctrl_reg;
		if (clr_all) begin
			ctrl_next = `CFP_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_next = reg_wdata[`CFP_CTRL_W-1:0] & `CFP_CTRL_WMASK;
		end
		if (high_live | stop_live) begin
			ctrl_next[`CFP_C_EN +: 3] = 3'b000;
		end
	end

	assign lim_next = clr_all ? `CFP_LIM_RST : (lim_wr ? reg_wdata[7:0] : lim_reg);

	always_comb begin
		dev_next = DEV_STANDBY;
		if (!sup_ok) begin
			dev_next = DEV_SHUTDOWN;
		end else if (|sw_next) begin
			dev_next = DEV_ACTIVE;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	wire [15:0]               stat_word = {1'b0, dev_reg, ecc_reg,
		flag_reg[`CFP_F_SHORT + 2], |flag_reg[`CFP_F_SHORT +: 2], run_now,
		high_live, stop_live, warn_live, peak_live};

	always_comb begin
		case (reg_addr)
			`CFP_ADDR_CTRL: rdata_next = {6'h00, ctrl_reg};
			`CFP_ADDR_FLAG: rdata_next = {6'h00, flag_reg};
			`CFP_ADDR_STAT: rdata_next = stat_word;
			`CFP_ADDR_LIM:  rdata_next = {8'h00, lim_reg};
			default:        rdata_next = 16'h0000;
		endcase
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg   <= `CFP_CTRL_RST;
			flag_reg   <= `CFP_FLAG_RST;
			lim_reg    <= `CFP_LIM_RST;
			warn_d_reg <= 1'b0;
			dev_reg    <= DEV_SHUTDOWN;
		end else begin
			ctrl_reg   <= ctrl_next;
			flag_reg   <= flag_next;
			lim_reg    <= lim_next;
			warn_d_reg <= warn_live;
			dev_reg    <= dev_next;
		end
	end

	// Memory check results are kept until power-on reset so a lockout cannot hide them.
	always_ff @(posedge clk) begin
		if (rst) begin
			ecc_reg <= 2'b00;
		end else begin
			ecc_reg <= ecc_reg | {ecc_double, ecc_single};
		end
	end

	// ****************************************
	// Output registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata               <= 16'h0000;
			irq_out_n               <= 1'b1;
			sw_en                   <= 3'b000;
			pulldown_en             <= 3'b000;
			gpo_force_low           <= 1'b0;
			dev_state               <= DEV_SHUTDOWN;
			stepdown_peak_limit_sel <= 6'h00;
			stepup_peak_limit_sel   <= 2'h0;
			hot_warn_level_sel      <= 1'b0;
		end else begin
			reg_rdata               <= reg_rd ? rdata_next : 16'h0000;
			irq_out_n               <= irq_next;
			sw_en                   <= sw_next;
			pulldown_en             <= pd_next;
			gpo_force_low           <= high_live;
			dev_state               <= dev_next;
			stepdown_peak_limit_sel <= lim_next[5:0];
			stepup_peak_limit_sel   <= lim_next[7:6];
			hot_warn_level_sel      <= ctrl_next[`CFP_C_WLVL];
		end
	end

endmodule // cfp_top

// file: verif/cfp_top_sva.sv
// Concurrent checks on the ports of the fault flag block.
`timescale 1ns/100ps
`include "cfp_cfg.svh"
module cfp_top_sva #(
	parameter int unsigned CYC_FAULT = 40000
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [7:0]        reg_addr,
	input wire logic              reg_wr,
	input wire logic [1:0]        sd_peak_raw,
	input wire logic [1:0]        sd_ramp,
	input wire logic              su_collapse_raw,
	input wire logic              hot_stop_raw,
	input wire logic              input_high_raw,
	input wire logic              main_supply_ok_raw,
	input wire logic              irq_out_n,
	input wire logic [2:0]        sw_en,
	input wire logic [2:0]        pulldown_en,
	input wire logic              gpo_force_low,
	input wire logic [1:0]        dev_state
);
	import cfp_pkg::*;
	// ****************************************
	// Checks
	// ****************************************
	// A host clear restarts the count, since the flag is only set once per episode.
	logic [16:0] pk_cnt;
	wire         pk_restart = rst || !sd_peak_raw[0] || sd_ramp[0] || !sw_en[0]
		|| (reg_wr && reg_addr == `CFP_ADDR_FLAG);
	always_ff @(posedge clk) begin
		if (pk_restart) begin
			pk_cnt <= 17'h00000;
		end else if (pk_cnt != 17'h1FFFF) begin
			pk_cnt <= pk_cnt + 17'h00001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_limit_irq_low: assert property (pk_cnt == 17'(CYC_FAULT + 820) |-> !irq_out_n)
		else $error("limit held long but interrupt high");
	a_collapse_stop: assert property (su_collapse_raw [*4] |-> !sw_en[2])
		else $error("step-up still switching after collapse");
	a_pull_exclusive: assert property ((sw_en & pulldown_en) == 3'h0)
		else $error("pulldown on while switching");
	a_ovp_kill_all: assert property (input_high_raw [*5] |-> sw_en == 3'h0 && gpo_force_low)
		else $error("overvoltage left outputs running");
	a_ovp_refuse_en: assert property (gpo_force_low |-> sw_en == 3'h0)
		else $error("converter enabled during overvoltage");
	a_ovp_irq_low: assert property (gpo_force_low [*2] |-> !irq_out_n)
		else $error("interrupt high with overvoltage pending");
	a_hot_stop_all: assert property (hot_stop_raw [*5]
		|-> sw_en == 3'h0 && dev_state != DEV_ACTIVE)
		else $error("hot stop left converters running");
	a_lockout_all: assert property ((!main_supply_ok_raw) [*5]
		|-> dev_state == DEV_SHUTDOWN && pulldown_en == 3'h7 && sw_en == 3'h0)
		else $error("lockout did not shut down");
endmodule // cfp_top_sva
bind cfp_top cfp_top_sva #(.CYC_FAULT(CYC_FAULT)) i_sva (
	.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .sd_peak_raw(sd_peak_raw),
	.sd_ramp(sd_ramp), .su_collapse_raw(su_collapse_raw), .hot_stop_raw(hot_stop_raw),
	.input_high_raw(input_high_raw), .main_supply_ok_raw(main_supply_ok_raw),
	.irq_out_n(irq_out_n), .sw_en(sw_en), .pulldown_en(pulldown_en),
	.gpo_force_low(gpo_force_low), .dev_state(dev_state));

// file: verif/cfp_host.sv
// Host model: register bus master that services the interrupt line.
`timescale 1ns/100ps
`include "cfp_cfg.svh"
module cfp_host (
	input  wire logic        clk,
	input  wire logic        irq_out_n,
	input  wire logic [15:0] reg_rdata,
	output logic      [7:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd
);
	// ****************************************
	// Bus cycles
	// ****************************************
	initial begin
		reg_addr = 8'hFF;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines show inverted values so a stale address is never mistaken for valid.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task automatic service();
		logic [15:0] f;
		if (!irq_out_n) begin
			rd(`CFP_ADDR_FLAG, f);
			wr(`CFP_ADDR_FLAG, f);
		end
	endtask
endmodule // cfp_host

// file: verif/tb_cfp_top.sv
// Self-checking bench of the fault flag block.
`timescale 1ns/100ps
`include "cfp_cfg.svh"
module tb_cfp_top;
	import cfp_pkg::*;
	localparam int CF = 20;
	localparam logic [7:0] AC = `CFP_ADDR_CTRL;
	localparam logic [7:0] AF = `CFP_ADDR_FLAG;
	localparam logic [7:0] AS = `CFP_ADDR_STAT;
	localparam logic [7:0] AL = `CFP_ADDR_LIM;
	logic clk = 0, rst = 1, su_peak = 0, su_col = 0, hot_warn = 0, hot_stop = 0;
	logic in_high = 0, sup_ok = 1, ecc_s = 0, ecc_d = 0, irq_out_n, gpo, reg_wr, reg_rd;
	logic su_low = 0, wlvl_sel;
	logic [5:0] sd_lim_sel;
	logic [1:0] su_lim_sel;
	logic [1:0] sd_peak = 0, sd_low = 0, sd_ramp = 0;
	logic [2:0] sw_en, pulldown_en;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	cfp_dev_e dev_state;
	int miscompares = 0, num_checks = 0;
	cfp_top #(.CYC_FAULT(CF)) i_dut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sd_peak_raw(sd_peak), .su_peak_raw(su_peak), .sd_low_raw(sd_low),
		.su_low_raw(su_low), .su_collapse_raw(su_col), .hot_warn_raw(hot_warn),
		.hot_stop_raw(hot_stop), .input_high_raw(in_high), .main_supply_ok_raw(sup_ok),
		.sd_ramp(sd_ramp), .ecc_single(ecc_s), .ecc_double(ecc_d),
		.irq_out_n(irq_out_n), .sw_en(sw_en), .pulldown_en(pulldown_en),
		.gpo_force_low(gpo), .dev_state(dev_state), .stepdown_peak_limit_sel(sd_lim_sel),
		.stepup_peak_limit_sel(su_lim_sel), .hot_warn_level_sel(wlvl_sel));
	cfp_host i_host (.clk(clk), .irq_out_n(irq_out_n), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] m, e);
		logic [15:0] d;
		i_host.rd(a, d);
		chk(n, e, d & m);
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		cyc(8);
		chk("irq", 0, irq_out_n);
		rchk("rstflag", AF, 16'h0200, 16'h0200);
		rchk("ctrl", AC, 16'hFFFF, 16'h0000);
		rchk("unmapped", 8'h7F, 16'hFFFF, 16'h0000);
		i_host.service();
		cyc(2);
		chk("irq", 1, irq_out_n);
	endtask
	task automatic t_short();
		@(posedge clk) sd_low[0] <= 1;
		i_host.wr(AC, 16'h0009);
		cyc(CF - 6);
		chk("sw0", 1, sw_en[0]);
		cyc(12);
		chk("sw0", 0, sw_en[0]);
		chk("pd0", 1, pulldown_en[0]);
		chk("irq", 0, irq_out_n);
		rchk("sflag", AF, 16'h0038, 16'h0008);
		rchk("sstat", AS, 16'h0240, 16'h0200);
		@(posedge clk) sd_low[0] <= 0;
		i_host.wr(AF, 16'h0008);
		cyc(3);
		chk("sw0", 1, sw_en[0]);
		cyc(CF + 4);
		rchk("run", AS, 16'h0240, 16'h0040);
	endtask
	task automatic t_limit();
		i_host.wr(AC, 16'h000D);
		cyc(CF + 6);
		@(posedge clk) sd_peak[0] <= 1;
		cyc(700);
		@(posedge clk) sd_peak[0] <= 0;
		rchk("lim", AF, 16'h0007, 16'h0000);
		@(posedge clk) sd_ramp[0] <= 1;
		sd_peak[0] <= 1;
		cyc(900);
		rchk("lim", AF, 16'h0001, 16'h0000);
		@(posedge clk) sd_ramp[0] <= 0;
		cyc(780);
		rchk("lim", AF, 16'h0001, 16'h0000);
		cyc(20);
		rchk("lim", AF, 16'h0001, 16'h0001);
		chk("irq", 0, irq_out_n);
		cyc(40);
		chk("irq", 0, irq_out_n);
		@(posedge clk) sd_peak[0] <= 0;
		su_peak <= 1;
		cyc(2500);
		rchk("sulim", AF, 16'h0004, 16'h0000);
		cyc(80);
		rchk("sulim", AF, 16'h0004, 16'h0004);
		@(posedge clk) su_peak <= 0;
		i_host.wr(AF, 16'h0005);
	endtask
	task automatic t_collapse();
		@(posedge clk) su_col <= 1;
		cyc(4);
		chk("sw2", 0, sw_en[2]);
		rchk("col", AF, 16'h0020, 16'h0000);
		cyc(CF);
		rchk("col", AF, 16'h0020, 16'h0020);
		rchk("sustat", AS, 16'h0500, 16'h0400);
		@(posedge clk) su_col <= 0;
		su_low <= 1;
		i_host.wr(AF, 16'h0020);
		cyc(3);
		chk("sw2", 1, sw_en[2]);
		cyc(CF);
		chk("sw2", 0, sw_en[2]);
		rchk("sulow", AF, 16'h0020, 16'h0020);
		@(posedge clk) su_low <= 0;
		i_host.wr(AF, 16'h0020);
		i_host.wr(AC, 16'h0000);
	endtask
	task automatic t_hot();
		@(posedge clk) hot_warn <= 1;
		cyc(5);
		rchk("warn", AF, 16'h0040, 16'h0040);
		rchk("wlive", AS, 16'h0008, 16'h0008);
		chk("irq", 0, irq_out_n);
		i_host.wr(AC, 16'h0040);
		cyc(2);
		chk("irq", 1, irq_out_n);
		i_host.wr(AF, 16'h0040);
		rchk("warn", AF, 16'h0040, 16'h0000);
		@(posedge clk) hot_warn <= 0;
		i_host.wr(AC, 16'h0000);
	endtask
	task automatic t_kill(input bit k);
		logic [15:0] f, l;
		f = k ? 16'h0080 : 16'h0100;
		l = k ? 16'h0010 : 16'h0020;
		i_host.wr(AC, 16'h0001);
		cyc(4);
		@(posedge clk) {hot_stop, in_high} <= k ? 2'b10 : 2'b01;
		cyc(5);
		chk("sw", 0, sw_en);
		chk("gpo", !k, gpo);
		chk("dev", DEV_STANDBY, dev_state);
		chk("irq", 0, irq_out_n);
		rchk("live", AS, l, l);
		i_host.wr(AF, f);
		rchk("kflag", AF, f, f);
		@(posedge clk) {hot_stop, in_high} <= 2'b00;
		cyc(3);
		i_host.wr(AC, 16'h0001);
		cyc(3);
		chk("sw", 0, sw_en);
		i_host.wr(AF, f);
		rchk("kflag", AF, f, 16'h0000);
		cyc(1);
		chk("sw", 1, sw_en);
	endtask
	task automatic t_lock();
		i_host.wr(AC, 16'h0208);
		i_host.wr(AL, 16'h00A5);
		cyc(1);
		chk("wlvl", 1, wlvl_sel);
		chk("sdsel", 16'h0025, sd_lim_sel);
		chk("susel", 16'h0002, su_lim_sel);
		rchk("lim", AL, 16'hFFFF, 16'h00A5);
		@(posedge clk) sup_ok <= 0;
		cyc(5);
		chk("dev", DEV_SHUTDOWN, dev_state);
		chk("pd", 3'h7, pulldown_en);
		@(posedge clk) sup_ok <= 1;
		cyc(6);
		chk("dev", DEV_STANDBY, dev_state);
		chk("wlvl", 0, wlvl_sel);
		chk("sdsel", 0, sd_lim_sel);
		chk("susel", 0, su_lim_sel);
		rchk("lim", AL, 16'hFFFF, 16'h0000);
		rchk("ctrl", AC, 16'hFFFF, 16'h0000);
		rchk("rstflag", AF, 16'h0200, 16'h0200);
		i_host.service();
		i_host.wr(AC, 16'h0100);
		cyc(8);
		rchk("rstflag", AF, 16'h0200, 16'h0200);
		i_host.wr(AC, 16'h0080);
		cyc(2);
		chk("irq", 1, irq_out_n);
		i_host.wr(AF, 16'h0200);
	endtask
	task automatic t_ecc();
		@(posedge clk) ecc_s <= 1;
		@(posedge clk) ecc_s <= 0;
		rchk("ecc", AS, 16'h1800, 16'h0800);
		@(posedge clk) ecc_d <= 1;
		@(posedge clk) ecc_d <= 0;
		rchk("ecc", AS, 16'h1800, 16'h1800);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		t_reset();
		t_short();
		t_limit();
		t_collapse();
		t_hot();
		t_kill(0);
		t_kill(1);
		t_lock();
		t_ecc();
		test_done();
	end
endmodule // tb_cfp_top
